// *** common/ssc_pkg.sv ***
// Constants, types and timing for the soft-start and strap-decode block
package ssc_pkg;
  localparam int CLK_MHZ = 25;
  localparam int BIAS_TIMEOUT_US = 5500;
  localparam int BIAS_TIMEOUT_WORST_US = 6500;
  localparam int INIT_DELAY_US = 200;
  localparam int BIAS_TIMEOUT_CYC = BIAS_TIMEOUT_US * CLK_MHZ;
  localparam int INIT_DELAY_CYC = INIT_DELAY_US * CLK_MHZ;
  localparam int FAULT_RETRY_US = 9000;
  localparam int FAULT_RETRY_CYC = FAULT_RETRY_US * CLK_MHZ;
  localparam int REF_W = 10;
  localparam int DAC_LSB_UV = 5000;
  localparam int CLK_PERIOD_NS = 1000 / CLK_MHZ;
  localparam int STEP_W = 12;
  localparam logic [7:0] CMD_STRAP_TWO = 8'h00_DD;
  localparam logic [7:0] CMD_STRAP_THREE = 8'h00_DE;
  localparam logic [7:0] CMD_STRAP_FOUR = 8'h00_DF;
  localparam logic [7:0] PFM_OFF_CODE = 8'h00_80;
  localparam logic [6:0] ADDR_BASE = 7'h00_60;
  localparam int P2_PFM_BIT = 7;
  localparam int P2_TEMP_HI = 6;
  localparam int P2_TEMP_LO = 5;
  localparam int P2_ADDR_HI = 4;
  localparam int P3_ULTRASONIC_LIGHT_LOAD_ENABLE_BIT = 7;
  localparam int P3_FAULT_BIT = 6;
  localparam int P3_FSW_HI = 5;
  localparam int P3_FSW_LO = 3;
  localparam int P3_GAIN_HI = 2;
  localparam int P4_RATE_HI = 7;
  localparam int P4_RATE_LO = 5;
  localparam int P4_RR_HI = 4;
  localparam int P4_RR_LO = 3;
  localparam int P4_MULT_BIT = 2;

  // Slew rates in uV/us for select codes 0..7
  function automatic int rate_uv_per_us(input logic [2:0] sel);
    case (sel)
      3'h0: rate_uv_per_us = 1250;
      3'h1: rate_uv_per_us = 2500;
      3'h2: rate_uv_per_us = 5000;
      3'h3: rate_uv_per_us = 10000;
      3'h4: rate_uv_per_us = 78;
      3'h5: rate_uv_per_us = 157;
      3'h6: rate_uv_per_us = 315;
      default: rate_uv_per_us = 625;
    endcase
  endfunction

  // Clock cycles per reference LSB at a given rate
  function automatic logic [STEP_W-1:0] step_cycles(input logic [2:0] sel);
    int c;
    c = (DAC_LSB_UV * 1000) / (rate_uv_per_us(sel) * CLK_PERIOD_NS);
    if (c < 1) begin
      c = 1;
    end
    step_cycles = STEP_W'(c);
  endfunction

  typedef enum logic [2:0] {
    SSC_IDLE = 3'b000,
    SSC_BIAS_WAIT = 3'b001,
    SSC_INIT_DELAY = 3'b010,
    SSC_STARTUP_RAMP = 3'b011,
    SSC_HOLD = 3'b100,
    SSC_TARGET_RAMP = 3'b101
  } ssc_state_t;

  typedef struct packed {
    logic pfm_enable;
    logic [1:0] temp_comp_sel;
    logic [6:0] bus_address_select;
    logic ultrasonic_light_load_enable;
    logic fault_latch;
    logic [2:0] fsw_sel;
    logic [2:0] loop_gain_sel;
    logic [2:0] ramp_rate_sel;
    logic [1:0] loop_impedance_select;
    logic gain_multiplier;
  } ssc_config_t;
endpackage

// *** rtl/ssc_softstart_config_sequencer.sv ***
// Soft-start reference sequencer with strap-code decode and readback
`timescale 1ns/10ps
// What this block does
// - Wait bias timeout after enable rises
// - Fixed initial delay, reference held still
// - Ramp reference zero to startup target
// - Hold startup target until new command
// - Valid command ramps reference to command
// - Early command redirects the startup ramp
// - Stepped ramp paced by selected slew rate
// - No PWM until reference reaches precharge
// - Low precharge: ramp up, then power good
// - High precharge: climb to it, ramp down, then power good
// - Decode PFM, temperature compensation, bus address
// - Decode ultrasonic, fault, frequency, gain fields
// - Decode slew rate, impedance, gain multiplier
// - Code two bit fields 7, 6:5, 4:0
// - Code four bits 7:5 pick ramp rate
// - Fault bit selects latch or 9ms retry
// - Strap codes readable by commands DD-DF
module ssc_softstart_config_sequencer #(
  parameter int BIAS_CYC = ssc_pkg::BIAS_TIMEOUT_CYC,
  parameter int DELAY_CYC = ssc_pkg::INIT_DELAY_CYC,
  parameter int RETRY_CYC = ssc_pkg::FAULT_RETRY_CYC
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic enable_in,
  input wire logic [7:0] strap_code_two,
  input wire logic [7:0] strap_code_three,
  input wire logic [7:0] strap_code_four,
  input wire logic [ssc_pkg::REF_W-1:0] startup_target_voltage,
  input wire logic [ssc_pkg::REF_W-1:0] overvoltage_limit,
  input wire logic [ssc_pkg::REF_W-1:0] precharge_level,
  input wire logic vout_cmd_valid,
  input wire logic [ssc_pkg::REF_W-1:0] vout_cmd_code,
  input wire logic rate_override_en,
  input wire logic [2:0] rate_override_sel,
  input wire logic rd_strobe,
  input wire logic [7:0] rd_cmd,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic rd_error,
  output logic [ssc_pkg::REF_W-1:0] ref_code,
  output logic pwm_enable,
  output logic power_good_flag,
  output logic [2:0] seq_phase,
  output ssc_pkg::ssc_config_t config_out,
  output logic [31:0] fault_retry_cycles
);
  localparam int CNT_W = 32;

  // Straps are captured one cycle after reset release, never at reset itself
  logic strap_taken_q, strap_taken_d;
  logic [7:0] code2_q, code2_d, code3_q, code3_d, code4_q, code4_d;
  ssc_pkg::ssc_config_t cfg_q, cfg_d;
  logic [31:0] retry_q, retry_d;

  always_comb begin
    strap_taken_d = 1'b1;
    code2_d = code2_q;
    code3_d = code3_q;
    code4_d = code4_q;
    if (!strap_taken_q) begin
      code2_d = strap_code_two;
      code3_d = strap_code_three;
      code4_d = strap_code_four;
    end
    cfg_d.pfm_enable = (code2_q < ssc_pkg::PFM_OFF_CODE);
    cfg_d.temp_comp_sel = code2_q[ssc_pkg::P2_TEMP_HI:ssc_pkg::P2_TEMP_LO];
    // Address field 00h gives 60h, 1Fh gives 7Fh
    cfg_d.bus_address_select = ssc_pkg::ADDR_BASE
      | {2'b00, code2_q[ssc_pkg::P2_ADDR_HI:0]};
    cfg_d.ultrasonic_light_load_enable = code3_q[ssc_pkg::P3_ULTRASONIC_LIGHT_LOAD_ENABLE_BIT];
    cfg_d.fault_latch = code3_q[ssc_pkg::P3_FAULT_BIT];
    cfg_d.fsw_sel = code3_q[ssc_pkg::P3_FSW_HI:ssc_pkg::P3_FSW_LO];
    cfg_d.loop_gain_sel = code3_q[ssc_pkg::P3_GAIN_HI:0];
    cfg_d.ramp_rate_sel = code4_q[ssc_pkg::P4_RATE_HI:ssc_pkg::P4_RATE_LO];
    cfg_d.loop_impedance_select = code4_q[ssc_pkg::P4_RR_HI:ssc_pkg::P4_RR_LO];
    cfg_d.gain_multiplier = code4_q[ssc_pkg::P4_MULT_BIT];
    // Zero retry interval means latch off; the fault logic lives elsewhere
    retry_d = code3_q[ssc_pkg::P3_FAULT_BIT] ? 32'h0000_0000 : 32'(RETRY_CYC);
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      strap_taken_q <= 1'b0;
      code2_q <= 8'h00_00;
      code3_q <= 8'h00_00;
      code4_q <= 8'h00_00;
      cfg_q <= '0;
      retry_q <= 32'h0000_0000;
    end else if (clk_en) begin
      strap_taken_q <= strap_taken_d;
      code2_q <= code2_d;
      code3_q <= code3_d;
      code4_q <= code4_d;
      cfg_q <= cfg_d;
      retry_q <= retry_d;
    end
  end

  // Readback of the captured codes
  logic [7:0] rd_data_q, rd_data_d;
  logic rd_valid_q, rd_valid_d, rd_error_q, rd_error_d;

  always_comb begin
    rd_data_d = 8'h00_00;
    rd_valid_d = rd_strobe;
    rd_error_d = 1'b0;
    if (rd_strobe) begin
      case (rd_cmd)
        ssc_pkg::CMD_STRAP_TWO: rd_data_d = code2_q;
        ssc_pkg::CMD_STRAP_THREE: rd_data_d = code3_q;
        ssc_pkg::CMD_STRAP_FOUR: rd_data_d = code4_q;
        default: rd_error_d = 1'b1;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rd_data_q <= 8'h00_00;
      rd_valid_q <= 1'b0;
      rd_error_q <= 1'b0;
    end else if (clk_en) begin
      rd_data_q <= rd_data_d;
      rd_valid_q <= rd_valid_d;
      rd_error_q <= rd_error_d;
    end
  end

  // Sequencer
  ssc_pkg::ssc_state_t state_q, state_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [ssc_pkg::STEP_W-1:0] step_q, step_d;
  logic [ssc_pkg::REF_W-1:0] ref_q, ref_d, tgt_q, tgt_d;
  logic pg_q, pg_d, pwm_q, pwm_d, high_pre_q, high_pre_d;
  logic [2:0] rate_sel;
  logic at_tgt;

  assign rate_sel = rate_override_en ? rate_override_sel : cfg_q.ramp_rate_sel;
  assign at_tgt = (ref_q == tgt_q);

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    step_d = step_q;
    ref_d = ref_q;
    tgt_d = tgt_q;
    pg_d = pg_q;
    pwm_d = pwm_q;
    high_pre_d = high_pre_q;
    // Stepping is shared by both ramp states
    if ((state_q == ssc_pkg::SSC_STARTUP_RAMP || state_q == ssc_pkg::SSC_TARGET_RAMP)
        && !at_tgt) begin
      if (step_q >= ssc_pkg::step_cycles(rate_sel) - 1'b1) begin
        step_d = '0;
        // One LSB per step, so the code lands on the target and never passes it
        ref_d = (ref_q < tgt_q) ? ref_q + 1'b1 : ref_q - 1'b1;
      end else begin
        step_d = step_q + 1'b1;
      end
    end
    // Switching waits until the reference meets the precharged output
    if (!pwm_q && state_q != ssc_pkg::SSC_IDLE && state_q != ssc_pkg::SSC_BIAS_WAIT
        && state_q != ssc_pkg::SSC_INIT_DELAY && ref_q >= precharge_level) begin
      pwm_d = 1'b1;
    end
    case (state_q)
      ssc_pkg::SSC_IDLE: begin
        if (enable_in) begin
          state_d = ssc_pkg::SSC_BIAS_WAIT;
          cnt_d = '0;
        end
      end
      ssc_pkg::SSC_BIAS_WAIT: begin
        cnt_d = cnt_q + 1'b1;
        if (cnt_q >= CNT_W'(BIAS_CYC - 1)) begin
          state_d = ssc_pkg::SSC_INIT_DELAY;
          cnt_d = '0;
        end
      end
      ssc_pkg::SSC_INIT_DELAY: begin
        cnt_d = cnt_q + 1'b1;
        if (cnt_q >= CNT_W'(DELAY_CYC - 1)) begin
          state_d = ssc_pkg::SSC_STARTUP_RAMP;
          step_d = '0;
          // Precharge above target but under the limit: climb to it first
          high_pre_d = (precharge_level > startup_target_voltage)
            && (precharge_level < overvoltage_limit);
          tgt_d = high_pre_d ? precharge_level : startup_target_voltage;
        end
      end
      ssc_pkg::SSC_STARTUP_RAMP: begin
        if (vout_cmd_valid) begin
          state_d = ssc_pkg::SSC_TARGET_RAMP;
          tgt_d = vout_cmd_code;
        end else if (at_tgt && high_pre_q) begin
          high_pre_d = 1'b0;
          tgt_d = startup_target_voltage;
        end else if (at_tgt) begin
          state_d = ssc_pkg::SSC_HOLD;
          pg_d = 1'b1;
        end
      end
      ssc_pkg::SSC_HOLD: begin
        if (vout_cmd_valid) begin
          state_d = ssc_pkg::SSC_TARGET_RAMP;
          tgt_d = vout_cmd_code;
          step_d = '0;
        end
      end
      ssc_pkg::SSC_TARGET_RAMP: begin
        if (vout_cmd_valid) begin
          tgt_d = vout_cmd_code;
        end else if (at_tgt) begin
          state_d = ssc_pkg::SSC_HOLD;
          pg_d = 1'b1;
        end
      end
      default: state_d = ssc_pkg::SSC_IDLE;
    endcase
    if (!enable_in) begin
      state_d = ssc_pkg::SSC_IDLE;
      cnt_d = '0;
      step_d = '0;
      ref_d = '0;
      tgt_d = '0;
      pg_d = 1'b0;
      pwm_d = 1'b0;
      high_pre_d = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_q <= ssc_pkg::SSC_IDLE;
      cnt_q <= '0;
      step_q <= '0;
      ref_q <= '0;
      tgt_q <= '0;
      pg_q <= 1'b0;
      pwm_q <= 1'b0;
      high_pre_q <= 1'b0;
    end else if (clk_en) begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      step_q <= step_d;
      ref_q <= ref_d;
      tgt_q <= tgt_d;
      pg_q <= pg_d;
      pwm_q <= pwm_d;
      high_pre_q <= high_pre_d;
    end
  end

  assign rd_data = rd_data_q;
  assign rd_valid = rd_valid_q;
  assign rd_error = rd_error_q;
  assign ref_code = ref_q;
  assign pwm_enable = pwm_q;
  assign power_good_flag = pg_q;
  assign seq_phase = state_q;
  assign config_out = cfg_q;
  assign fault_retry_cycles = retry_q;
endmodule

// *** sim/ssc_host_model.sv ***
// Bus host model issuing output voltage commands
`timescale 1ns/10ps
module ssc_host_model (
  input wire logic ref_clk,
  output logic vout_cmd_valid,
  output logic [ssc_pkg::REF_W-1:0] vout_cmd_code
);
  initial begin
    vout_cmd_valid = 1'b0;
    vout_cmd_code = '0;
  end
  // One-cycle command pulse; code turns over once released
  // Output level is not simulated, so no bleed-down wait is modelled
  task automatic send(input logic [ssc_pkg::REF_W-1:0] code);
    @(negedge ref_clk);
    vout_cmd_valid = 1'b1;
    vout_cmd_code = code;
    @(negedge ref_clk);
    vout_cmd_valid = 1'b0;
    vout_cmd_code = ~code;
  endtask
endmodule

// *** sim/ssc_checker_properties.sv ***
// Port-level concurrent checks for the sequencer
`timescale 1ns/10ps
module ssc_checker #(
  parameter int DELAY_CYC = 10
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic enable_in,
  input wire logic vout_cmd_valid,
  input wire logic rd_strobe,
  input wire logic [7:0] rd_cmd,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid,
  input wire logic rd_error,
  input wire logic [ssc_pkg::REF_W-1:0] ref_code,
  input wire logic power_good_flag,
  input wire logic [2:0] seq_phase
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  // Counts enabled edges spent in the initial delay; a frozen clock must not count
  logic [15:0] dly_q;
  logic [15:0] dly_d;
  always_comb dly_d = (seq_phase == 3'h2) ? dly_q + {15'h0000, clk_en} : 16'h0000;
  always_ff @(posedge ref_clk) dly_q <= reset ? 16'h0000 : dly_d;

  a_read_answer: assert property (clk_en && rd_strobe |=> rd_valid)
    else $error("read not answered");
  a_read_refuse: assert property (clk_en && rd_strobe
    && !(rd_cmd inside {8'hDD, 8'hDE, 8'hDF}) |=> rd_error && rd_data == 8'h00)
    else $error("unmapped read not refused");
  a_start_bias: assert property (clk_en && seq_phase == 3'h0
    && enable_in |=> seq_phase == 3'h1) else $error("bias wait not entered");
  a_delay_still: assert property (seq_phase == 3'h2
    && $past(seq_phase) == 3'h2 |-> $stable(ref_code)) else $error("reference moved in delay");
  a_delay_bound: assert property (seq_phase == 3'h2 |-> dly_q < DELAY_CYC)
    else $error("initial delay too long");
  a_ramp_step: assert property (seq_phase inside {3'h3, 3'h5}
    && $past(seq_phase) == seq_phase
    |-> ref_code - $past(ref_code) inside {10'h000, 10'h001, 10'h3FF}) else $error("ramp jump");
  a_hold_still: assert property (seq_phase == 3'h4
    && $past(seq_phase) == 3'h4 |-> $stable(ref_code)) else $error("reference moved in hold");
  a_cmd_redirect: assert property (clk_en && vout_cmd_valid
    && seq_phase == 3'h3 |=> seq_phase == 3'h5) else $error("command did not redirect");
  a_pg_drop: assert property (clk_en && !enable_in |=> !power_good_flag)
    else $error("power good kept without enable");
  a_pg_hold: assert property ($rose(power_good_flag) |-> seq_phase == 3'h4)
    else $error("power good outside hold");
endmodule
bind ssc_softstart_config_sequencer ssc_checker #(.DELAY_CYC(DELAY_CYC)) chk (.ref_clk, .reset,
  .clk_en, .enable_in, .vout_cmd_valid, .rd_strobe, .rd_cmd, .rd_data, .rd_valid, .rd_error,
  .ref_code, .power_good_flag, .seq_phase);

// *** sim/test_softstart_config_sequencer.sv ***
// Self-checking bench for the soft-start sequencer
`timescale 1ns/10ps
module test_softstart_config_sequencer;
  logic ref_clk, reset, clk_en, enable_in, rd_strobe, rd_valid, rd_error;
  logic rate_override_en, pwm_enable, power_good_flag, vout_cmd_valid;
  logic [7:0] strap_code_two, strap_code_three, strap_code_four, rd_cmd, rd_data;
  logic [2:0] rate_override_sel, seq_phase;
  logic [9:0] startup_target_voltage, overvoltage_limit, precharge_level, ref_code;
  logic [9:0] vout_cmd_code, peak, r;
  logic [31:0] fault_retry_cycles;
  ssc_pkg::ssc_config_t config_out;
  int n_mismatch = 0, check_count = 0, n;
  // Short counts keep the run brief; expectations below use these values
  ssc_softstart_config_sequencer #(.BIAS_CYC(20), .DELAY_CYC(10), .RETRY_CYC(100)) uut (
    .ref_clk, .reset, .clk_en, .enable_in, .strap_code_two, .strap_code_three,
    .strap_code_four, .startup_target_voltage, .overvoltage_limit, .precharge_level,
    .vout_cmd_valid, .vout_cmd_code, .rate_override_en, .rate_override_sel, .rd_strobe,
    .rd_cmd, .rd_data, .rd_valid, .rd_error, .ref_code, .pwm_enable, .power_good_flag,
    .seq_phase, .config_out, .fault_retry_cycles);
  ssc_host_model host (.ref_clk, .vout_cmd_valid, .vout_cmd_code);

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic setup(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
    reset = 1'b1;
    {strap_code_two, strap_code_three, strap_code_four} = {a, b, c};
    repeat (3) @(negedge ref_clk);
    reset = 1'b0;
    repeat (4) @(negedge ref_clk);
  endtask

  // Returns {valid, error, data} one cycle after the strobe is taken
  task automatic rd(input logic [7:0] cmd, output logic [9:0] res);
    @(negedge ref_clk);
    rd_strobe = 1'b1;
    rd_cmd = cmd;
    @(negedge ref_clk);
    rd_strobe = 1'b0;
    rd_cmd = ~cmd;
    res = {rd_valid, rd_error, rd_data};
  endtask

  task automatic wait_phase(input logic [2:0] p, output int k);
    k = 0;
    while (seq_phase !== p && k < 3000) begin
      @(negedge ref_clk);
      k++;
    end
  endtask

  // Cycles between two reference steps, skipping a possibly partial first one
  task automatic step_len(output int k);
    logic [9:0] v;
    for (int i = 0; i < 2; i++) begin
      v = ref_code;
      k = 0;
      while (ref_code === v && k < 3000) begin
        @(negedge ref_clk);
        k++;
      end
    end
  endtask

  always @(negedge ref_clk) begin
    if (seq_phase inside {3'h0, 3'h1, 3'h2}) peak = 10'h000;
    if (seq_phase inside {3'h3, 3'h5} && ref_code > peak) peak = ref_code;
    // Switching may stay on once the reference has met the precharge, even if it walks down
    if (seq_phase == 3'h3 && peak < precharge_level) chk(pwm_enable, 1'b0);
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    n_mismatch++;
    report_and_stop();
  end

  initial begin
    {clk_en, enable_in, rd_strobe, rd_cmd, rate_override_en, rate_override_sel} = 15'h4000;
    {startup_target_voltage, overvoltage_limit, precharge_level} = {10'h006, 10'h014, 10'h002};
    setup(8'h9F, 8'h5F, 8'h7F);
    chk(config_out[23:14], {1'h0, 2'h0, 7'h7F});
    chk(config_out[13:0], {1'h0, 1'h1, 3'h3, 3'h7, 3'h3, 2'h3, 1'h1});
    chk(fault_retry_cycles, 32'h0000_0000);
    rd(8'hDD, r); chk(r, 10'h29F);
    rd(8'hDE, r); chk(r, 10'h25F);
    rd(8'hDF, r); chk(r, 10'h27F);
    rd(8'hDC, r); chk(r, 10'h300);
    enable_in = 1'b1;
    wait_phase(3'h1, n);
    wait_phase(3'h2, n); chk(n, 20);
    wait_phase(3'h3, n); chk(n, 10);
    chk(ref_code, 10'h000);
    wait_phase(3'h4, n); chk({pwm_enable, power_good_flag, ref_code}, 12'hC06);
    host.send(10'h009);
    step_len(n); chk(n, 12);
    wait_phase(3'h4, n); chk(ref_code, 10'h009);
    {rate_override_en, rate_override_sel} = 4'hA;
    host.send(10'h003);
    step_len(n); chk(n, 25);
    wait_phase(3'h4, n); chk(ref_code, 10'h003);
    enable_in = 1'b0;
    rate_override_en = 1'b0;
    @(negedge ref_clk); chk({power_good_flag, seq_phase}, 4'h0);
    enable_in = 1'b1;
    wait_phase(3'h3, n);
    repeat (30) @(negedge ref_clk);
    host.send(10'h001);
    wait_phase(3'h4, n); chk({ref_code, peak < 10'h006}, 11'h003);
    enable_in = 1'b0;
    precharge_level = 10'h008;
    @(negedge ref_clk);
    enable_in = 1'b1;
    wait_phase(3'h4, n); chk({power_good_flag, ref_code, peak}, 21'h10_1808);
    enable_in = 1'b0;
    setup(8'h60, 8'hA0, 8'hE0);
    chk(config_out[23:14], {1'h1, 2'h3, 7'h60});
    chk(config_out[13:0], {1'h1, 1'h0, 3'h4, 3'h0, 3'h7, 2'h0, 1'h0});
    chk(fault_retry_cycles, 32'h0000_0064);
    chk(seq_phase, 3'h0);
    // Precharge at the limit is no high precharge: plain ramp, and switching never starts
    overvoltage_limit = 10'h008;
    enable_in = 1'b1;
    clk_en = 1'b0;
    repeat (4) @(negedge ref_clk);
    chk(seq_phase, 3'h0);
    clk_en = 1'b1;
    @(negedge ref_clk);
    chk(seq_phase, 3'h1);
    wait_phase(3'h4, n);
    chk({pwm_enable, power_good_flag, ref_code, peak}, 22'h10_1806);
    report_and_stop();
  end
endmodule
